// *** common/flc_regs.vh ***
`ifndef FLC_REGS_VH
`define FLC_REGS_VH
// Storage element behaviour codes
`define FLC_FF_D        2'h0
`define FLC_FF_T        2'h1
`define FLC_FF_JK       2'h2
`define FLC_FF_SR       2'h3
// Clock / clear source select codes
`define FLC_SRC_GLOBAL  2'h0
`define FLC_SRC_PIN     2'h1
`define FLC_SRC_LOGIC   2'h2
// Clock enable source select codes
`define FLC_CE_PIN      1'h0
`define FLC_CE_LOGIC    1'h1
// Register data source select codes
`define FLC_DIN_LUT     2'h0
`define FLC_DIN_DIRECT  2'h1
`define FLC_DIN_CHAIN   2'h2
// Output source select
`define FLC_OUT_LUT     1'h0
`define FLC_OUT_REG     1'h1
// Lookup table input count, truth width and reset values
`define FLC_LUT_IN_W    4
`define FLC_LUT_BITS    16
`define FLC_MASK_RESET  16'h0000
`define FLC_CFG_RESET   2'h0
`endif

// *** logic/flc_src_sync.v ***
`include "flc_regs.vh"
// Two-flop synchroniser for a source that arrives from a pin
module flc_src_sync (
  input  wire core_clk,  // Clock
  input  wire reset_n,   // Async reset, active low
  input  wire din,       // Asynchronous input
  output reg  dout       // Synchronised level
);
  reg meta;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // flc_src_sync

// *** logic/flc_logic_cell.v ***
`include "flc_regs.vh"
// Functional notes
// [R01] The lookup table takes four inputs and can realise any function of them.
// [R02] The storage element behaves as a D, T, JK or SR flip-flop chosen by configuration.
// [R03] The storage element has data, clock, clock-enable and clear inputs.
// [R04] Clock and clear come from global, pin or logic; clock enable from pin or logic only.
// [R05] A combinational function routes the table result straight to the outputs; here it passes one core_clk output register on the way.
// [R06] Three outputs are each sourced independently from the table or the register.
// [R07] Two outputs feed row/column and direct-link routing, one feeds the cluster-local net.
// [R08] Register packing lets the table drive one output and the register another.
// [R09] While packing is in use the cluster synchronous load has no effect on this register.
// [R10] Register feedback returns the register output as a table input of this cell.
// [R11] Registered and unregistered table results may appear on outputs together.
// [R12] A register-chain output cascades the register into the next register of the cluster.
// [R13] Synchronous clear and load are cluster-wide and act on every register; load skips a register while packing is in use.
// [R14] The device-wide clear resets every register and overrides all other controls.
// [R15] A register has either clear or preset; preset inverts data and output around clear.
// [R16] The register updates only on an enabled clock edge and otherwise holds. Here both clears act without a clock edge.
module flc_logic_cell #(
  parameter LUT_IN_W = `FLC_LUT_IN_W, // Table input count
  parameter LUT_BITS = `FLC_LUT_BITS  // Table truth bits, two to the input count
) (
  input  wire                core_clk,            // Fabric clock
  input  wire                reset_n,             // Async reset, active low
  input  wire                device_wide_clear_n, // Device-wide clear pin, active low
  input  wire [LUT_BITS-1:0] lut_mask,            // Table truth contents
  input  wire [LUT_IN_W-1:0] lut_in,              // Table data inputs
  input  wire                fb_en,               // Replace top table input with register
  input  wire [1:0]          ff_mode,             // D, T, JK or SR behaviour
  input  wire [1:0]          din_sel,             // Register data from table, direct or chain
  input  wire                din_direct,          // Direct register data input
  input  wire                j_in,                // J or S input
  input  wire                k_in,                // K or R input
  input  wire                chain_in,            // Register chain from previous cell
  input  wire [1:0]          clk_sel,             // Clock source select
  input  wire                clk_global,          // Global clock tick
  input  wire                clk_pin,             // Pin clock
  input  wire                clk_logic,           // Logic clock
  input  wire                ce_sel,              // Clock enable source select
  input  wire                ce_pin,              // Pin clock enable
  input  wire                ce_logic,            // Logic clock enable
  input  wire [1:0]          clr_sel,             // Clear source select
  input  wire                clr_global,          // Global clear
  input  wire                clr_pin,             // Pin clear
  input  wire                clr_logic,           // Logic clear
  input  wire                preset_mode,         // Clear acts as preset
  input  wire                cluster_sclr,        // Cluster synchronous clear
  input  wire                cluster_sload,       // Cluster synchronous load
  input  wire                sload_data,          // Synchronous load value
  input  wire                pack_en,             // Register packing in use
  input  wire [2:0]          out_sel,             // Per output table or register
  output reg                 out_row,             // Row or column routing output
  output reg                 out_direct,          // Direct-link routing output
  output reg                 out_local,           // Cluster-local output
  output reg                 chain_out            // Register chain output
);
  // ************************************************************
  // Input capture
  // ************************************************************
  // Global nets and pins arrive from outside the fabric clock
  wire pin_clk_s;
  wire glb_clk_s;
  wire pin_ce_s;
  wire pin_clr_s;
  wire glb_clr_s;
  wire dev_clr_s;

  flc_src_sync u_sync_clk (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (clk_pin),
    .dout     (pin_clk_s)
  );

  flc_src_sync u_sync_gclk (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (clk_global),
    .dout     (glb_clk_s)
  );

  flc_src_sync u_sync_ce (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (ce_pin),
    .dout     (pin_ce_s)
  );

  flc_src_sync u_sync_clr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (clr_pin),
    .dout     (pin_clr_s)
  );

  flc_src_sync u_sync_gclr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (clr_global),
    .dout     (glb_clr_s)
  );

  flc_src_sync u_sync_dev (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .din      (~device_wide_clear_n),
    .dout     (dev_clr_s)
  );

  // ************************************************************
  // Source selection
  // ************************************************************
  function sel3;
    input [1:0] sel;
    input       a;
    input       b;
    input       c;
    begin
      case (sel)
        `FLC_SRC_GLOBAL: sel3 = a;
        `FLC_SRC_PIN:    sel3 = b;
        `FLC_SRC_LOGIC:  sel3 = c;
        default:         sel3 = a;
      endcase
    end
  endfunction

  reg  tick_prev;
  reg  tick_armed;
  wire tick_src = sel3(clk_sel, glb_clk_s, pin_clk_s, clk_logic);  // see [R04]
  wire ce_src   = (ce_sel == `FLC_CE_LOGIC) ? ce_logic : pin_ce_s;  // see [R04]
  wire clr_src  = sel3(clr_sel, glb_clr_s, pin_clr_s, clr_logic);  // see [R04]
  // No edge in the first cycle after reset, whatever the idle level of the tick
  wire edge_hit = tick_armed & tick_src & ~tick_prev;

  // ************************************************************
  // Lookup table
  // ************************************************************
  reg                 ff_q;
  wire                q_vis   = ff_q ^ preset_mode;                         // see [R15]
  wire [LUT_IN_W-1:0] lut_idx = {fb_en ? q_vis : lut_in[LUT_IN_W-1],
                                 lut_in[LUT_IN_W-2:0]};                     // see [R10]
  wire                lut_out = lut_mask[lut_idx];                          // see [R01]

  // ************************************************************
  // Storage element
  // ************************************************************
  function ff_step;
    input [1:0] mode;
    input       q;
    input       d;
    input       j;
    input       k;
    begin
      case (mode)
        `FLC_FF_D:  ff_step = d;
        `FLC_FF_T:  ff_step = q ^ d;
        `FLC_FF_JK: ff_step = (j & ~q) | (~k & q);
        `FLC_FF_SR: ff_step = j | (~k & q);
        default:    ff_step = q;
      endcase
    end
  endfunction

  reg data_bit;
  reg next_q;
  always @* begin
    case (din_sel)
      `FLC_DIN_DIRECT: data_bit = din_direct;
      `FLC_DIN_CHAIN:  data_bit = chain_in;                       // see [R12]
      default:         data_bit = lut_out;
    endcase
  end

  // Next value in visible polarity, stored inverted for preset
  always @* begin
    next_q = ff_step(ff_mode, q_vis, data_bit, j_in, k_in);       // see [R02]
    if (cluster_sload && !pack_en) begin                          // see [R09]
      next_q = sload_data;                                        // see [R13]
    end
    if (cluster_sclr) begin
      next_q = 1'b0;                                              // see [R13]
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ff_q       <= 1'b0;
      tick_prev  <= 1'b0;
      tick_armed <= 1'b0;
    end else begin
      tick_prev  <= tick_src;
      tick_armed <= 1'b1;
      if (dev_clr_s) begin
        ff_q <= 1'b0;                                             // see [R14]
      end else if (clr_src) begin
        ff_q <= 1'b0;                                             // see [R15]
      end else if (edge_hit && ce_src) begin                      // see [R03] see [R16]
        ff_q <= next_q ^ preset_mode;                             // see [R15]
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  function pick_out;
    input sel;
    input reg_bit;
    input lut_bit;
    begin
      pick_out = (sel == `FLC_OUT_REG) ? reg_bit : lut_bit;
    end
  endfunction

  // Table path bypasses the storage register but passes an output flop; each of the three routing outputs picks its own source
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_row    <= 1'b0;
      out_direct <= 1'b0;
      out_local  <= 1'b0;
      chain_out  <= 1'b0;
    end else begin
      out_row    <= pick_out(out_sel[0], q_vis, lut_out);         // see [R05] see [R06] see [R07]
      out_direct <= pick_out(out_sel[1], q_vis, lut_out);         // see [R07] see [R08] see [R11]
      out_local  <= pick_out(out_sel[2], q_vis, lut_out);         // see [R07]
      chain_out  <= q_vis;                                        // see [R12]
    end
  end
endmodule // flc_logic_cell

// *** tb/flc_logic_cell_checker.sv ***
module flc_logic_cell_checker (
  input wire logic        core_clk,            // Fabric clock
  input wire logic        reset_n,             // Async reset, active low
  input wire logic        device_wide_clear_n, // Device-wide clear, active low
  input wire logic [15:0] lut_mask,            // Table contents
  input wire logic [3:0]  lut_in,              // Table inputs
  input wire logic        fb_en,               // Register feedback
  input wire logic [1:0]  ff_mode,             // Storage behaviour
  input wire logic [1:0]  din_sel,             // Register data source
  input wire logic        din_direct,          // Direct data
  input wire logic [1:0]  clk_sel,             // Clock source
  input wire logic        clk_logic,           // Logic tick
  input wire logic        ce_sel,              // Enable source
  input wire logic        ce_logic,            // Logic enable
  input wire logic [1:0]  clr_sel,             // Clear source
  input wire logic        clr_logic,           // Logic clear
  input wire logic        preset_mode,         // Clear acts as preset
  input wire logic        cluster_sclr,        // Cluster synchronous clear
  input wire logic        cluster_sload,       // Cluster synchronous load
  input wire logic        sload_data,          // Load value
  input wire logic        pack_en,             // Register packing
  input wire logic [2:0]  out_sel,             // Output sources
  input wire logic        out_row,             // Row output
  input wire logic        out_direct,          // Direct-link output
  input wire logic        chain_out            // Register chain output
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic lut_q;
  wire tick_ok = clk_sel == 2'h2 && ce_sel && ce_logic && clr_sel == 2'h2 && !clr_logic
    && device_wide_clear_n && !preset_mode && !cluster_sclr;
  always @(posedge core_clk) lut_q <= lut_mask[lut_in];
  AST_ROW_TABLE: assert property (!out_sel[0] && !fb_en |=> out_row == lut_q)
    else $error("row output not table result");
  AST_DIRECT_TABLE: assert property (!out_sel[1] && !fb_en |=> out_direct == lut_q)
    else $error("direct output not table result");
  AST_REG_HOLD: assert property ((clk_sel == 2'h2 && clr_sel == 2'h2 && !clr_logic &&
    device_wide_clear_n && !preset_mode && $stable(clk_logic)) [*6] |=> $stable(chain_out))
    else $error("register changed without tick");
  AST_CLEAR: assert property (clr_sel == 2'h2 && clr_logic && !preset_mode ##1 !preset_mode
    |-> ##1 !chain_out)
    else $error("clear did not clear");
  AST_PRESET: assert property (clr_sel == 2'h2 && clr_logic && preset_mode ##1 preset_mode
    |-> ##1 chain_out)
    else $error("preset did not set");
  AST_DEV_CLEAR: assert property ((!device_wide_clear_n && !preset_mode) [*4] ##1 !preset_mode
    |-> ##1 !chain_out)
    else $error("device clear ignored");
  AST_D_CAPTURE: assert property (tick_ok && !cluster_sload && ff_mode == 2'h0 && din_sel == 2'h1
    && $past(device_wide_clear_n) && $past(device_wide_clear_n, 2) && $rose(clk_logic)
    ##1 !preset_mode |-> ##1 chain_out == $past(din_direct, 2))
    else $error("D capture wrong");
  AST_SLOAD: assert property (tick_ok && cluster_sload && !pack_en && $rose(clk_logic)
    && $past(device_wide_clear_n) && $past(device_wide_clear_n, 2)
    ##1 !preset_mode |-> ##1 chain_out == $past(sload_data, 2))
    else $error("synchronous load wrong");
endmodule // flc_logic_cell_checker
bind flc_logic_cell flc_logic_cell_checker u_chk (.*);

// *** tb/flc_neighbour_cell.sv ***
module flc_neighbour_cell (
  input  wire logic core_clk, // Clock
  input  wire logic reset_n,  // Async reset, active low
  input  wire logic tick,     // Shared register tick
  input  wire logic shift_in, // Data for this register
  output logic      chain_q   // Chain into the next cell
);
  timeunit 1ns; timeprecision 1ps;
  logic tick_d;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_d  <= 1'b0;
      chain_q <= 1'b0;
    end else begin
      tick_d <= tick;
      if (tick && !tick_d) chain_q <= shift_in;
    end
  end
endmodule // flc_neighbour_cell

// *** tb/flc_logic_cell_tb_top.sv ***
module flc_logic_cell_tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic core_clk = 0, reset_n = 0, device_wide_clear_n = 1, fb_en = 0, din_direct = 0, j_in = 0;
  logic k_in = 0, clk_global = 0, clk_pin = 0, clk_logic = 0, ce_sel = 1, ce_pin = 0, ce_logic = 1;
  logic clr_global = 0, clr_pin = 0, clr_logic = 0, preset_mode = 0, cluster_sclr = 0, nb_in = 0;
  logic cluster_sload = 0, sload_data = 0, pack_en = 0, q = 0, nq = 0;
  logic [15:0] lut_mask = 16'h0000;
  logic [3:0] lut_in = 4'h0;
  logic [2:0] out_sel = 3'h0, pv = 3'h2;
  logic [1:0] ff_mode = 2'h0, din_sel = 2'h1, clk_sel = 2'h2, clr_sel = 2'h2;
  wire out_row, out_direct, out_local, chain_out, chain_in;
  int miscompares = 0, checks_done = 0, cyc = 0;
  flc_logic_cell u_dut (.*);
  flc_neighbour_cell u_nb (.core_clk, .reset_n, .tick(clk_logic), .shift_in(nb_in), .chain_q(chain_in));
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 4000) begin miscompares++; complete_run(); end
  function automatic logic lut(logic r);
    return lut_mask[{fb_en ? r : lut_in[3], lut_in[2:0]}];
  endfunction
  function automatic logic ff_next(logic r);
    if (ff_mode == 2'h0) return din_direct;
    if (ff_mode == 2'h1) return r ^ din_direct;
    if (ff_mode == 2'h2 && j_in && k_in) return !r;
    return j_in | (r & !k_in);
  endfunction
  task automatic chk(string n, logic e, logic s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic tick;
    @(posedge core_clk) clk_logic <= 1;
    @(posedge core_clk) clk_logic <= 0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic outs;
    chk("out_row", out_sel[0] ? q : lut(q), out_row);
    chk("out_direct", out_sel[1] ? q : lut(q), out_direct);
    chk("out_local", out_sel[2] ? q : lut(q), out_local);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8D2E));
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    repeat (16) begin
      @(posedge core_clk);
      {lut_mask, lut_in, out_sel, fb_en} <= 24'($urandom);
      {clk_global, clk_pin, ce_pin, clr_global, clr_pin} <= 5'($urandom);
      repeat (2) @(posedge core_clk);
      #1 outs();
    end
    $display("table routing test done");
    repeat (40) begin
      @(posedge core_clk);
      {ff_mode, din_direct, j_in, k_in, cluster_sload, sload_data, pack_en, ce_logic} <= 10'($urandom);
      cluster_sclr <= ($urandom % 6) == 0;
      #1;
      nq = !ce_logic ? q : cluster_sclr ? 0 : cluster_sload && !pack_en ? sload_data : ff_next(q);
      tick();
      q = nq;
      chk("chain_out", q, chain_out);
      outs();
    end
    $display("register mode test done");
    @(posedge core_clk);
    fb_en <= 1;
    lut_mask <= 16'hFF00;
    out_sel <= 3'h0;
    ce_logic <= 1;
    cluster_sclr <= 0;
    cluster_sload <= 0;
    din_sel <= 2'h2;
    ff_mode <= 2'h0;
    repeat (2) @(posedge core_clk);
    #1 chk("feedback", q, out_row);
    nq = 0;
    repeat (6) begin
      @(posedge core_clk);
      nb_in <= 1'($urandom);
      tick();
      q = nq;
      nq = nb_in;
      chk("chain", q, chain_out);
    end
    $display("feedback and chain test done");
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      clr_logic <= 1;
      preset_mode <= pv[i];
      repeat (3) @(posedge core_clk);
      #1 chk("clear", pv[i], chain_out);
    end
    @(posedge core_clk);
    {clr_logic, din_sel, din_direct} <= 4'h3;
    tick();
    chk("load one", 1, chain_out);
    @(posedge core_clk) device_wide_clear_n <= 0;
    tick();
    tick();
    chk("device clear", 0, chain_out);
    q = 0;
    @(posedge core_clk) device_wide_clear_n <= 1;
    repeat (8) @(posedge core_clk);
    $display("clear test done");
    clk_global <= 0;
    ce_pin <= 1;
    ce_sel <= 0;
    din_sel <= 2'h0;
    fb_en <= 0;
    lut_mask <= 16'($urandom);
    lut_in <= 4'($urandom);
    repeat (4) @(posedge core_clk);
    clk_sel <= 2'h0;
    repeat (2) @(posedge core_clk);
    clk_global <= 1;
    @(posedge core_clk) clk_global <= 0;
    repeat (6) @(posedge core_clk);
    #1 q = lut(q);
    chk("global tick", q, chain_out);
    outs();
    $display("global source test done");
    complete_run();
  end
endmodule // flc_logic_cell_tb_top
